// ===== logic/data_eeprom_write_control.sv
// Contract
// R1: Software loads address and data registers before starting a write.
// R2: Write start is accepted only on the write right after arming.
// R3: Write start without write-arm already set is ignored; no cycle begins.
// R4: Software masks global interrupts around arming and starting a write.
// R5: Write cycle is timed by an internal timer, not a fixed clock count.
// R6: Hardware clears write-start when the write cycle ends.
// R7: Reset clears write-arm.
// R8: Reset sets bank 0; control register reachable only in bank 1.
// R9: Completion event raised at end of every write or read cycle.
// R10: Interrupt needs both the EEPROM enable and the multi-function enable.
// R11: Write end sets the EEPROM flag and the multi-function flag; the code sets the multi-function flag only if the EEPROM enable is set.
// R12: Vector only with all three enables set and stack not full.
// R13: Vector entry clears only the multi-function flag; software clears EEPROM flag.
// R14: Software avoids idle or sleep while a cycle is running.
// R15: Software keeps arm and bank cleared when idle; may read back.
// R16: Software reaches control via pointer 40h, bank 01h, indirect port.
// R17: After completion software clears control, then bank selector.
// R18: Control bits: write-arm 3, write-start 2, read-arm 1, read-start 0.
// R19: 64 bytes, 6-bit address; upper address bits read zero.
// R20: Read starts only if read-arm set; at end start clears, data loaded.
// R21: Software never sets both starts, nor all four bits together.
// R22: During a cycle further starts and address or data writes are ignored.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_write_control
	import eeprom_ctl_pkg::*;
#(
	parameter int TIMER_DIV = TIMER_DIV_DEFAULT,
	parameter int WRITE_TICKS = WRITE_TICKS_DEFAULT,
	parameter int READ_TICKS = READ_TICKS_DEFAULT
) (
	input wire logic aclk, // System clock, 25 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic stack_full, // Return stack of the core is full
	output logic irq_vector, // Pulse: jump to multi-function vector
	output logic eeprom_busy // A write or read cycle is running
);

	////////////////////////////////////////////////////////////////////////
	// Register state

	logic [EE_ADDR_W-1:0] eeprom_address_reg;
	logic [7:0] eeprom_data_reg;
	ctrl_bits_t eeprom_control_reg;
	logic [7:0] bank_selector;
	logic [7:0] indirect_pointer;
	irq_en_t irq_en;
	logic eeprom_irq_flag;
	logic multi_irq_flag;
	logic arm_fresh;
	ee_state_t state;

	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic w_lane0;
	logic aw_full;
	logic w_full;
	logic do_write;

	logic ctrl_visible;
	logic [7:0] rdata_word;
	logic [7:0] array_rdata;
	logic cycle_done;
	logic start_write;
	logic start_read;
	ctrl_bits_t new_ctrl;
	logic ctrl_write;
	logic flag_clear_ee;
	logic flag_clear_multi;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == ADDR_REG_OFS) || (a == DATA_REG_OFS) || (a == BANK_REG_OFS) ||
			(a == POINTER_REG_OFS) || (a == INDIRECT_REG_OFS) || (a == IRQ_EN_REG_OFS) ||
			(a == IRQ_FLAG_REG_OFS);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channels: address and data taken in either order

	assign s_axi_awready = !aw_full;
	assign s_axi_wready = !w_full;
	assign do_write = aw_full && w_full && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && !aw_full) begin
			aw_full <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full <= 1'b0;
			w_data <= 32'h0000_0000;
			w_lane0 <= 1'b0;
		end else if (s_axi_wvalid && !w_full) begin
			w_full <= 1'b1;
			w_data <= s_axi_wdata;
			w_lane0 <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_full <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write decode

	// Control register only answers through the indirect port in bank 1
	assign ctrl_visible = (bank_selector == CTRL_BANK) && (indirect_pointer == CTRL_POINTER); // R8 R16
	assign ctrl_write = do_write && w_lane0 && (aw_addr == INDIRECT_REG_OFS) && ctrl_visible;
	assign new_ctrl = w_data[3:0];

	// Arm must already be set and the previous bus write must have set it
	assign start_write = ctrl_write && new_ctrl.write_start && new_ctrl.write_arm &&
		eeprom_control_reg.write_arm && arm_fresh && !new_ctrl.read_start &&
		(state == ST_IDLE); // R2 R3 R22
	assign start_read = ctrl_write && new_ctrl.read_start && eeprom_control_reg.read_arm &&
		!new_ctrl.write_start && (state == ST_IDLE); // R20 R22

	assign flag_clear_ee = do_write && w_lane0 && (aw_addr == IRQ_FLAG_REG_OFS) && w_data[EEPROM_FLAG_BIT];
	assign flag_clear_multi = do_write && w_lane0 && (aw_addr == IRQ_FLAG_REG_OFS) && w_data[MULTI_FLAG_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bank_selector <= BANK_RESET; // R8
			indirect_pointer <= POINTER_RESET;
			irq_en <= '0;
		end else if (do_write && w_lane0) begin
			if (aw_addr == BANK_REG_OFS) begin
				bank_selector <= w_data[7:0];
			end
			if (aw_addr == POINTER_REG_OFS) begin
				indirect_pointer <= w_data[7:0];
			end
			if (aw_addr == IRQ_EN_REG_OFS) begin
				irq_en <= w_data[2:0];
			end
		end
	end

	// Address and data stay frozen while a cycle uses them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eeprom_address_reg <= '0;
		end else if (do_write && w_lane0 && aw_addr == ADDR_REG_OFS && state == ST_IDLE) begin // R22
			eeprom_address_reg <= w_data[EE_ADDR_W-1:0]; // R19
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eeprom_data_reg <= 8'h00;
		end else if (cycle_done && state == ST_READING) begin
			eeprom_data_reg <= array_rdata; // R20
		end else if (do_write && w_lane0 && aw_addr == DATA_REG_OFS && state == ST_IDLE) begin // R22
			eeprom_data_reg <= w_data[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arm_fresh <= 1'b0;
		end else if (do_write) begin
			arm_fresh <= ctrl_write && new_ctrl.write_arm && !eeprom_control_reg.write_arm; // R2
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register and cycle sequencing

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eeprom_control_reg <= CTRL_RESET; // R7 R18
		end else begin
			if (ctrl_write) begin
				eeprom_control_reg.write_arm <= new_ctrl.write_arm;
				eeprom_control_reg.read_arm <= new_ctrl.read_arm;
			end
			// Start bits are owned by hardware while a cycle runs
			if (start_write) begin
				eeprom_control_reg.write_start <= 1'b1;
			end else if (cycle_done && state == ST_WRITING) begin
				eeprom_control_reg.write_start <= 1'b0; // R6
			end
			if (start_read) begin
				eeprom_control_reg.read_start <= 1'b1;
			end else if (cycle_done && state == ST_READING) begin
				eeprom_control_reg.read_start <= 1'b0; // R20
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_write) begin
						state <= ST_WRITING;
					end else if (start_read) begin
						state <= ST_READING;
					end
				end
				ST_WRITING, ST_READING: begin
					if (cycle_done) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	assign eeprom_busy = (state != ST_IDLE);

	eeprom_cycle_timer #(
		.TIMER_DIV(TIMER_DIV),
		.WRITE_TICKS(WRITE_TICKS),
		.READ_TICKS(READ_TICKS)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start_write(start_write), // R5
		.start_read(start_read),
		.done(cycle_done)
	);

	// Byte is committed as the timed cycle ends
	eeprom_cell_array #(
		.DEPTH(EE_DEPTH)
	) u_array (
		.aclk(aclk),
		.write_en(cycle_done && state == ST_WRITING),
		.addr(eeprom_address_reg),
		.wdata(eeprom_data_reg),
		.rdata(array_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Completion flags and vectoring

	// Completion sets win over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eeprom_irq_flag <= 1'b0;
		end else if (cycle_done && state != ST_IDLE) begin
			eeprom_irq_flag <= 1'b1; // R9 R11
		end else if (flag_clear_ee) begin
			eeprom_irq_flag <= 1'b0; // R13
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			multi_irq_flag <= 1'b0;
		end else if (cycle_done && state != ST_IDLE && irq_en.eeprom_en) begin
			multi_irq_flag <= 1'b1; // R10 R11
		end else if (irq_vector || flag_clear_multi) begin
			multi_irq_flag <= 1'b0; // R13
		end
	end

	// One pulse per request; entry clears the group flag and leaves the EEPROM flag set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_vector <= 1'b0;
		end else begin
			irq_vector <= !irq_vector && multi_irq_flag && irq_en.global_en && irq_en.eeprom_en &&
				irq_en.multi_en && !stack_full; // R10 R12
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel

	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		rdata_word = 8'h00;
		case (s_axi_araddr)
			ADDR_REG_OFS: rdata_word = {2'b00, eeprom_address_reg}; // R19
			DATA_REG_OFS: rdata_word = eeprom_data_reg;
			BANK_REG_OFS: rdata_word = bank_selector;
			POINTER_REG_OFS: rdata_word = indirect_pointer;
			INDIRECT_REG_OFS: rdata_word = ctrl_visible ? {4'h0, eeprom_control_reg} : 8'h00; // R8 R18
			IRQ_EN_REG_OFS: rdata_word = {5'h00, irq_en};
			IRQ_FLAG_REG_OFS: rdata_word = {6'h00, multi_irq_flag, eeprom_irq_flag};
			default: rdata_word = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rdata_word};
			s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== logic/eeprom_cell_array.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_cell_array
	import eeprom_ctl_pkg::*;
#(
	parameter int DEPTH = EE_DEPTH
) (
	input wire logic aclk, // System clock
	input wire logic write_en, // Commit one byte
	input wire logic [EE_ADDR_W-1:0] addr, // Byte index
	input wire logic [7:0] wdata, // Byte to store
	output logic [7:0] rdata // Byte at addr
);

	// Non-volatile contents are not touched by reset
	logic [7:0] cells [DEPTH];

	always_ff @(posedge aclk) begin
		if (write_en) begin
			cells[addr] <= wdata;
		end
	end

	assign rdata = cells[addr];

endmodule
`default_nettype wire

// ===== logic/eeprom_ctl_pkg.sv
package eeprom_ctl_pkg;

	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] ADDR_REG_OFS = 8'h00;
	localparam logic [7:0] DATA_REG_OFS = 8'h04;
	localparam logic [7:0] BANK_REG_OFS = 8'h08;
	localparam logic [7:0] POINTER_REG_OFS = 8'h0c;
	localparam logic [7:0] INDIRECT_REG_OFS = 8'h10;
	localparam logic [7:0] IRQ_EN_REG_OFS = 8'h14;
	localparam logic [7:0] IRQ_FLAG_REG_OFS = 8'h18;

	// Where the control register sits behind the indirect port
	localparam logic [7:0] CTRL_POINTER = 8'h40;
	localparam logic [7:0] CTRL_BANK = 8'h01;

	// Control register fields
	localparam int READ_START_BIT = 0;
	localparam int READ_ARM_BIT = 1;
	localparam int WRITE_START_BIT = 2;
	localparam int WRITE_ARM_BIT = 3;

	// Interrupt enable fields
	localparam int GLOBAL_EN_BIT = 0;
	localparam int EEPROM_EN_BIT = 1;
	localparam int MULTI_EN_BIT = 2;

	// Interrupt flag fields
	localparam int EEPROM_FLAG_BIT = 0;
	localparam int MULTI_FLAG_BIT = 1;

	// Reset values
	localparam logic [7:0] BANK_RESET = 8'h00;
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// Array geometry
	localparam int EE_ADDR_W = 6;
	localparam int EE_DEPTH = 64;

	// Self-timed cycle defaults: clocks per internal timer tick, then cycle lengths in ticks
	localparam int TIMER_DIV_DEFAULT = 25;
	localparam int WRITE_TICKS_DEFAULT = 2000;
	localparam int READ_TICKS_DEFAULT = 4;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic write_arm;
		logic write_start;
		logic read_arm;
		logic read_start;
	} ctrl_bits_t;

	typedef struct packed {
		logic multi_en;
		logic eeprom_en;
		logic global_en;
	} irq_en_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WRITING = 3'b010,
		ST_READING = 3'b100
	} ee_state_t;

endpackage

// ===== logic/eeprom_cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_cycle_timer
	import eeprom_ctl_pkg::*;
#(
	parameter int TIMER_DIV = TIMER_DIV_DEFAULT,
	parameter int WRITE_TICKS = WRITE_TICKS_DEFAULT,
	parameter int READ_TICKS = READ_TICKS_DEFAULT
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic start_write, // Pulse: begin a write cycle
	input wire logic start_read, // Pulse: begin a read cycle
	output logic done // Pulse: cycle finished
);

	// Free-running divider stands in for the internal oscillator; its phase is
	// unrelated to the start, so a cycle lasts a varying number of clocks.
	logic [15:0] div;
	logic [15:0] remaining;
	logic tick;

	assign tick = (div == 16'h0000);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div <= 16'h0000;
		end else if (tick) begin
			div <= 16'(TIMER_DIV - 1);
		end else begin
			div <= div - 16'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remaining <= 16'h0000;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start_write) begin
				remaining <= 16'(WRITE_TICKS);
			end else if (start_read) begin
				remaining <= 16'(READ_TICKS);
			end else if (tick && remaining != 16'h0000) begin
				remaining <= remaining - 16'h0001;
				done <= (remaining == 16'h0001);
			end
		end
	end

endmodule
`default_nettype wire

// ===== verif/eeprom_ctl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_ctl_asserts
	import eeprom_ctl_pkg::*;
#(
	parameter int TIMER_DIV = 2,
	parameter int WRITE_TICKS = 3,
	parameter int READ_TICKS = 2
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic s_axi_awvalid, // Write address valid
	input wire logic s_axi_awready, // Write address ready
	input wire logic s_axi_wvalid, // Write data valid
	input wire logic s_axi_wready, // Write data ready
	input wire logic s_axi_bvalid, // Response valid
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic stack_full, // Return stack full
	input wire logic irq_vector, // Vector pulse
	input wire logic eeprom_busy // Cycle running
);
	// Divider phase can only shorten the cycle; one clock for the done register, plus one clock of slack
	localparam int MAX_BUSY = WRITE_TICKS * TIMER_DIV + 2;
	int busy_cnt;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		if (!aresetn || !eeprom_busy) busy_cnt <= 0;
		else busy_cnt <= busy_cnt + 1;
	end
	////////////////////////////////////////////////////////////////
	property p_busy_len; busy_cnt <= MAX_BUSY; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy too long");
	property p_busy_start; $rose(eeprom_busy) |-> $rose(s_axi_bvalid); endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy without write");
	property p_reset_quiet; $rose(aresetn) |-> !eeprom_busy && !irq_vector && !s_axi_bvalid && !s_axi_rvalid; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle after reset");
	// A group flag left set after entry would make the vector toggle again
	property p_irq_pulse; irq_vector |=> !irq_vector [*2]; endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("vector pulse too long");
	property p_irq_stack; irq_vector |-> !$past(stack_full); endproperty
	a_irq_stack: assert property (p_irq_stack) else $error("vector with stack full");
	property p_rdata_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
	property p_b_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
	a_b_answer: assert property (p_b_answer) else $error("no write response");
	property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_answer: assert property (p_r_answer) else $error("no read response");
	property p_aw_block; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
	a_aw_block: assert property (p_aw_block) else $error("second write taken early");
endmodule
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import eeprom_ctl_pkg::*;
();
	localparam logic [7:0] AD = ADDR_REG_OFS, DT = DATA_REG_OFS, BK = BANK_REG_OFS, PT = POINTER_REG_OFS;
	localparam logic [7:0] CT = INDIRECT_REG_OFS, EN = IRQ_EN_REG_OFS, FL = IRQ_FLAG_REG_OFS;
	localparam logic [1:0] OK = RESP_OKAY;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, stack_full = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_vector, eeprom_busy;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int num_errors = 0, checked = 0, irqs = 0;
	data_eeprom_write_control #(.TIMER_DIV(2), .WRITE_TICKS(10), .READ_TICKS(2)) i_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.stack_full, .irq_vector, .eeprom_busy
	);
	always #20 aclk = ~aclk;
	always @(posedge aclk) if (irq_vector === 1'b1) irqs <= irqs + 1;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Valid and payload held until the edge that samples ready
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		s_axi_bready <= 1'b0;
		// A response that never came counts as a mismatch
		chk(32'(s_axi_bvalid), 32'h1);
		chk(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		s_axi_rready <= 1'b0;
		chk(32'(s_axi_rvalid), 32'h1);
		v = s_axi_rdata;
		chk(32'(s_axi_rresp), 32'(er));
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v, OK);
		chk(v, exp);
	endtask
	// Polls the control register until the given start bit drops
	task automatic poll(input int b);
		int n;
		logic [31:0] v;
		n = 0;
		do begin
			rd(CT, v, OK);
			n++;
		end while (v[b] !== 1'b0 && n < 30);
		chk({31'h0, v[b]}, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#400us;
		num_errors++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rc(BK, 32'h0);
		rc(PT, 32'h0);
		wr(CT, 8'h08, OK);
		wr(BK, CTRL_BANK, OK);
		wr(PT, CTRL_POINTER, OK);
		rc(CT, 32'h0);
		rd(8'h1c, d, RESP_SLVERR);
		wr(8'h1c, 8'h01, RESP_SLVERR);
		wr(AD, 8'hff, OK);
		rc(AD, 32'h3f);
		wr(DT, 8'ha5, OK);
		s_axi_wstrb <= 4'he;
		wr(DT, 8'h11, OK);
		s_axi_wstrb <= 4'hf;
		rc(DT, 32'ha5);
		wr(EN, 8'h06, OK);
		wr(CT, 8'h04, OK);
		rc(CT, 32'h0);
		wr(CT, 8'h08, OK);
		wr(DT, 8'ha5, OK);
		wr(CT, 8'h0c, OK);
		rc(CT, 32'h08);
		wr(CT, 8'h00, OK);
		wr(CT, 8'h0f, OK);
		rc(CT, 32'h0a);
		wr(CT, 8'h00, OK);
		wr(CT, 8'h08, OK);
		wr(CT, 8'h0c, OK);
		chk(32'(eeprom_busy), 32'h1);
		wr(EN, 8'h07, OK);
		wr(DT, 8'h00, OK);
		wr(AD, 8'h00, OK);
		rc(CT, 32'h0c);
		poll(WRITE_START_BIT);
		rc(FL, 32'h01);
		chk(32'(irqs), 32'h1);
		rc(AD, 32'h3f);
		rc(DT, 32'ha5);
		wr(FL, 8'h03, OK);
		rc(FL, 32'h0);
		wr(CT, 8'h00, OK);
		wr(DT, 8'h00, OK);
		wr(CT, 8'h02, OK);
		wr(CT, 8'h03, OK);
		poll(READ_START_BIT);
		rc(DT, 32'ha5);
		rc(FL, 32'h01);
		chk(32'(irqs), 32'h2);
		wr(FL, 8'h03, OK);
		stack_full <= 1'b1;
		wr(CT, 8'h03, OK);
		poll(READ_START_BIT);
		rc(FL, 32'h03);
		chk(32'(irqs), 32'h2);
		stack_full <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(32'(irqs), 32'h3);
		rc(FL, 32'h01);
		wr(FL, 8'h03, OK);
		wr(EN, 8'h05, OK);
		wr(CT, 8'h03, OK);
		poll(READ_START_BIT);
		rc(FL, 32'h01);
		chk(32'(irqs), 32'h3);
		wr(CT, 8'h08, OK);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(BK, 32'h0);
		wr(BK, CTRL_BANK, OK);
		wr(PT, CTRL_POINTER, OK);
		rc(CT, 32'h0);
		report_and_stop();
	end
endmodule
bind data_eeprom_write_control eeprom_ctl_asserts #(
	.TIMER_DIV(TIMER_DIV), .WRITE_TICKS(WRITE_TICKS), .READ_TICKS(READ_TICKS)
) i_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .stack_full, .irq_vector, .eeprom_busy
);
`default_nettype wire
